// >>> shared/cit_regs.vh
// Constants for the instruction timing decoder: register addresses, fields,
// opcodes and clock counts. Included by bare name from the design file.
`ifndef CIT_REGS_VH
`define CIT_REGS_VH

// Special register addresses and reset value.
`define CIT_ADDR_PTR_LOW  8'h82
`define CIT_ADDR_PTR_HIGH 8'h83
`define CIT_ADDR_STATUS   8'hD0
`define CIT_SFR_RESET     8'h00
`define CIT_BANK_RESET    2'h0
`define CIT_BANK_HI       4
`define CIT_BANK_LO       3
`define CIT_SFR_SPACE_BIT 7

// Clock counts and instruction lengths.
`define CIT_CYC_1         4'h1
`define CIT_CYC_2         4'h2
`define CIT_CYC_3         4'h3
`define CIT_CYC_4         4'h4
`define CIT_CYC_5         4'h5
`define CIT_CYC_6         4'h6
`define CIT_LEN_1         2'h1
`define CIT_LEN_2         2'h2
`define CIT_LEN_3         2'h3

// Single-code opcodes.
`define CIT_OP_IDLE       8'h00
`define CIT_OP_SPARE      8'hA5
`define CIT_OP_LONG_JUMP  8'h02
`define CIT_OP_LONG_CALL  8'h12
`define CIT_OP_RET        8'h22
`define CIT_OP_RETI       8'h32
`define CIT_OP_BIT_CLR_BR 8'h10
`define CIT_OP_JB         8'h20
`define CIT_OP_JNB        8'h30
`define CIT_OP_JC         8'h40
`define CIT_OP_JNC        8'h50
`define CIT_OP_JZ         8'h60
`define CIT_OP_JNZ        8'h70
`define CIT_OP_JMP_IND    8'h73
`define CIT_OP_SHORT_BR   8'h80
`define CIT_OP_LOAD_DP    8'h90
`define CIT_OP_CODE_PC    8'h83
`define CIT_OP_CODE_DP    8'h93
`define CIT_OP_MOV_DD     8'h85
`define CIT_OP_MOV_DI     8'h75
`define CIT_OP_ORL_DI     8'h43
`define CIT_OP_ANL_DI     8'h53
`define CIT_OP_XRL_DI     8'h63
`define CIT_OP_CMP_IMM_BR 8'hB4
`define CIT_OP_CMP_DIR_BR 8'hB5
`define CIT_OP_DEC_DIR_BR 8'hD5

// Opcode field positions.
`define CIT_PAGE_LOW5     5'h01
`define CIT_CALL_LOW5     5'h11
`define CIT_PAGE_BITS     11

`endif

// >>> hdl/cit_instruction_timing.v
// Instruction timing and operand address decoder for an 8-bit controller core,
// together with the data pointer bytes and the register bank select field.
// Assumes the fetch unit presents one whole instruction with its operand bytes
// and the evaluated branch condition, and that all inputs are synchronous to clk.
`timescale 1ns/1ps
`include "cit_regs.vh"

module cit_instruction_timing (
    input  wire        clk,
    input  wire        srst,
    input  wire        issueValid,
    input  wire [7:0]  opcode,
    input  wire [7:0]  operandOne,
    input  wire [7:0]  operandTwo,
    input  wire [15:0] nextPc,
    input  wire [7:0]  accValue,
    input  wire        condTrue,
    input  wire        sfrWrEn,
    input  wire        sfrRdEn,
    input  wire [7:0]  sfrAddr,
    input  wire [7:0]  sfrWrData,
    output reg  [7:0]  sfrRdData,
    output reg         sfrRdValid,
    output reg         busy,
    output reg         done,
    output reg  [3:0]  cycleCount,
    output reg  [1:0]  instrBytes,
    output reg         knownOp,
    output reg         branchTaken,
    output reg         targetValid,
    output reg  [15:0] targetAddr,
    output reg  [15:0] codeAddr,
    output reg  [7:0]  regAddr,
    output reg         directIsSfr,
    output reg         bitClear,
    output reg  [7:0]  bitClearAddr,
    output reg  [15:0] dataPointer,
    output reg  [1:0]  bankSelect
);

    // Execution counter and the pending clear of a tested bit.
    reg [3:0] remain;
    reg       pendClear;

    // Decoder results.
    reg [3:0]  decCycles;
    reg [3:0]  decTakenCycles;
    reg [1:0]  decBytes;
    reg        decKnown;
    reg        decCond;
    reg        decJump;
    reg        decRelLast;
    reg        decIndirect;
    reg [15:0] decTarget;
    reg [15:0] decCode;
    reg [7:0]  decReg;
    reg        decTaken;
    reg [3:0]  decFinal;

    wire accept = issueValid && (!busy || done);

    // Signed displacement added to the address of the following instruction.
    function [15:0] relTarget;
        input [15:0] base;
        input [7:0]  disp;
        begin
            relTarget = base + {{8{disp[7]}}, disp};
        end
    endfunction

    // Internal RAM address of a bank register in the selected bank.
    function [7:0] bankRegAddr;
        input [1:0] bank;
        input [2:0] index;
        begin
            bankRegAddr = {3'h0, bank, index};
        end
    endfunction

    // Decode the clock counts, length and addresses of the presented opcode.
    always @* begin
        decCycles      = `CIT_CYC_1;
        decTakenCycles = `CIT_CYC_1;
        decBytes       = `CIT_LEN_1;
        decKnown       = 1'b1;
        decCond        = 1'b0;
        decJump        = 1'b0;
        decRelLast     = 1'b0;
        decIndirect    = 1'b0;
        decTarget      = nextPc;
        decCode        = nextPc;
        decReg         = bankRegAddr(bankSelect, opcode[2:0]);
        // Rows are tried in order; the page forms are caught in the default branch
        // because their opcodes share only the low five bits.
        casez (opcode)
            // The spare opcode is decoded exactly like the idle instruction.
            `CIT_OP_IDLE, `CIT_OP_SPARE: begin
                decCycles = `CIT_CYC_1;
            end
            // Single-clock accumulator operations.
            8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hE4, 8'hF4: begin
                decCycles = `CIT_CYC_1;
            end
            // Three-byte moves and logic operations that write a direct byte.
            `CIT_OP_MOV_DD, `CIT_OP_MOV_DI, `CIT_OP_ORL_DI, `CIT_OP_ANL_DI, `CIT_OP_XRL_DI: begin
                decCycles = `CIT_CYC_3;
                decBytes  = `CIT_LEN_3;
            end
            // One-byte forms through a pointer register still need a RAM access.
            8'b1110_011?, 8'b1111_011?, 8'b1100_011?, 8'b1101_011?: begin
                decCycles   = `CIT_CYC_2;
                decIndirect = 1'b1;
            end
            // Two-byte pointer forms.
            8'b1000_011?, 8'b1010_011?, 8'b0111_011?: begin
                decCycles   = `CIT_CYC_2;
                decBytes    = `CIT_LEN_2;
                decIndirect = 1'b1;
            end
            `CIT_OP_LOAD_DP: begin
                decCycles = `CIT_CYC_3;
                decBytes  = `CIT_LEN_3;
            end
            `CIT_OP_CODE_DP: begin
                decCycles = `CIT_CYC_3;
                decCode   = dataPointer + {8'h00, accValue};
            end
            `CIT_OP_CODE_PC: begin
                decCycles = `CIT_CYC_3;
                decCode   = nextPc + {8'h00, accValue};
            end
            // External transfers with an 8-bit address from a pointer register.
            8'b1110_001?, 8'b1111_001?: begin
                decCycles   = `CIT_CYC_3;
                decIndirect = 1'b1;
            end
            // External transfers with a 16-bit address from the data pointer.
            8'hE0, 8'hF0: begin
                decCycles = `CIT_CYC_3;
                decCode   = dataPointer;
            end
            // Stack push and pop of a direct byte.
            8'hC0, 8'hD0: begin
                decCycles = `CIT_CYC_2;
                decBytes  = `CIT_LEN_2;
            end
            // Carry clear, set and complement.
            8'hC3, 8'hD3, 8'hB3: begin
                decCycles = `CIT_CYC_1;
            end
            8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92: begin
                decCycles = `CIT_CYC_2;
                decBytes  = `CIT_LEN_2;
            end
            // Bank register moves and exchanges: one byte, one clock.
            8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF,
            8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF,
            8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE, 8'hCF: begin
                decCycles = `CIT_CYC_1;
            end
            // Two-byte direct and immediate moves.
            8'hE5, 8'h74, 8'hF5, 8'hC5, 8'b1010_1???, 8'b0111_1???, 8'b1000_1???: begin
                decCycles = `CIT_CYC_2;
                decBytes  = `CIT_LEN_2;
            end
            // Two-byte conditional branches, displacement in the second byte.
            `CIT_OP_JC, `CIT_OP_JNC, `CIT_OP_JZ, `CIT_OP_JNZ, 8'b1101_1???: begin
                decCycles      = `CIT_CYC_2;
                decTakenCycles = `CIT_CYC_4;
                decBytes       = `CIT_LEN_2;
                decCond        = 1'b1;
            end
            // Three-byte conditional branches, displacement in the third byte.
            // The test-bit-clear form also arms the clear of its bit when the branch is taken.
            `CIT_OP_JB, `CIT_OP_JNB, `CIT_OP_BIT_CLR_BR, `CIT_OP_DEC_DIR_BR, `CIT_OP_CMP_IMM_BR, 8'b1011_1???: begin
                decCycles      = `CIT_CYC_3;
                decTakenCycles = `CIT_CYC_5;
                decBytes       = `CIT_LEN_3;
                decCond        = 1'b1;
                decRelLast     = 1'b1;
            end
            // Compare branches against a direct byte or through a pointer register.
            `CIT_OP_CMP_DIR_BR, 8'b1011_011?: begin
                decCycles      = `CIT_CYC_4;
                decTakenCycles = `CIT_CYC_6;
                decBytes       = `CIT_LEN_3;
                decCond        = 1'b1;
                decRelLast     = 1'b1;
                decIndirect    = opcode[1];
            end
            // Unconditional relative jump.
            `CIT_OP_SHORT_BR: begin
                decCycles = `CIT_CYC_4;
                decBytes  = `CIT_LEN_2;
                decJump   = 1'b1;
            end
            // Indirect jump from the data pointer plus the accumulator.
            `CIT_OP_JMP_IND: begin
                decCycles = `CIT_CYC_4;
                decJump   = 1'b1;
                decTarget = dataPointer + {8'h00, accValue};
            end
            // Long jump and call carry the full target, high byte first.
            `CIT_OP_LONG_JUMP, `CIT_OP_LONG_CALL: begin
                decCycles = `CIT_CYC_5;
                decBytes  = `CIT_LEN_3;
                decJump   = 1'b1;
                decTarget = {operandOne, operandTwo};
            end
            // Returns from a subroutine or an interrupt.
            `CIT_OP_RET, `CIT_OP_RETI: begin
                decCycles = `CIT_CYC_6;
            end
            // Page-target jumps and calls; anything else is left undecoded.
            default: begin
                if (opcode[4:0] == `CIT_PAGE_LOW5 || opcode[4:0] == `CIT_CALL_LOW5) begin
                    decCycles = `CIT_CYC_4;
                    decBytes  = `CIT_LEN_2;
                    decJump   = 1'b1;
                    decTarget = {nextPc[15:`CIT_PAGE_BITS], opcode[7:5], operandOne};
                end else begin
                    decKnown = 1'b0;
                end
            end
        endcase
        if (decIndirect) begin
            decReg = bankRegAddr(bankSelect, {2'h0, opcode[0]});
        end
        if (decCond || opcode == `CIT_OP_SHORT_BR) begin
            decTarget = relTarget(nextPc, decRelLast ? operandTwo : operandOne);
        end
        decTaken = decJump || (decCond && condTrue);
        decFinal = (decCond && condTrue) ? decTakenCycles : decCycles;
    end

    // Instruction sequencing: results stand from acceptance until the next one.
    always @(posedge clk) begin
        if (srst) begin
            remain       <= 4'h0;
            busy         <= 1'b0;
            done         <= 1'b0;
            cycleCount   <= 4'h0;
            instrBytes   <= 2'h0;
            knownOp      <= 1'b0;
            branchTaken  <= 1'b0;
            targetValid  <= 1'b0;
            targetAddr   <= 16'h0000;
            codeAddr     <= 16'h0000;
            regAddr      <= 8'h00;
            directIsSfr  <= 1'b0;
            pendClear    <= 1'b0;
            bitClear     <= 1'b0;
            bitClearAddr <= 8'h00;
        end else if (accept) begin
            remain       <= decFinal;
            busy         <= 1'b1;
            done         <= (decFinal == `CIT_CYC_1);
            cycleCount   <= decFinal;
            instrBytes   <= decBytes;
            knownOp      <= decKnown;
            branchTaken  <= decTaken;
            targetValid  <= decTaken;
            targetAddr   <= decTarget;
            codeAddr     <= decCode;
            regAddr      <= decReg;
            directIsSfr  <= operandOne[`CIT_SFR_SPACE_BIT];
            pendClear    <= (opcode == `CIT_OP_BIT_CLR_BR) && condTrue;
            bitClear     <= 1'b0;
            bitClearAddr <= operandOne;
        end else if (busy) begin
            remain    <= remain - 4'h1;
            busy      <= (remain != `CIT_CYC_1);
            done      <= (remain == `CIT_CYC_2);
            bitClear  <= pendClear && (remain == `CIT_CYC_2);
            pendClear <= pendClear && (remain != `CIT_CYC_2);
        end else begin
            done     <= 1'b0;
            bitClear <= 1'b0;
        end
    end

    // Data pointer bytes and bank select field; an immediate load wins over a register write.
    always @(posedge clk) begin
        if (srst) begin
            dataPointer <= {`CIT_SFR_RESET, `CIT_SFR_RESET};
            bankSelect  <= `CIT_BANK_RESET;
        end else begin
            if (sfrWrEn && sfrAddr == `CIT_ADDR_PTR_LOW) begin
                dataPointer[7:0] <= sfrWrData;
            end
            if (sfrWrEn && sfrAddr == `CIT_ADDR_PTR_HIGH) begin
                dataPointer[15:8] <= sfrWrData;
            end
            if (sfrWrEn && sfrAddr == `CIT_ADDR_STATUS) begin
                bankSelect <= sfrWrData[`CIT_BANK_HI:`CIT_BANK_LO];
            end
            if (accept && opcode == `CIT_OP_LOAD_DP) begin
                dataPointer <= {operandOne, operandTwo};
            end
        end
    end

    // Register reads answer one cycle later; unmapped addresses read as zero.
    always @(posedge clk) begin
        if (srst) begin
            sfrRdData  <= `CIT_SFR_RESET;
            sfrRdValid <= 1'b0;
        end else begin
            sfrRdValid <= sfrRdEn;
            case (sfrAddr)
                `CIT_ADDR_PTR_LOW:  sfrRdData <= dataPointer[7:0];
                `CIT_ADDR_PTR_HIGH: sfrRdData <= dataPointer[15:8];
                `CIT_ADDR_STATUS:   sfrRdData <= {3'h0, bankSelect, 3'h0};
                default:      sfrRdData <= `CIT_SFR_RESET;
            endcase
        end
    end

endmodule // cit_instruction_timing

// >>> tb/cit_code_mem.sv
// Code memory model: the byte at the fetch address and the two after it.
// Assumes the bench fills a location through put before pointing there.
`timescale 1ns/1ps
module cit_code_mem (
    input  wire logic [15:0] addr,
    output wire logic [7:0]  b0,
    output wire logic [7:0]  b1,
    output wire logic [7:0]  b2
);
    logic [7:0] mem [0:255];
    // Opcode and operand bytes, wrapping inside the window.
    assign b0 = mem[addr[7:0]];
    assign b1 = mem[8'(addr[7:0] + 8'h01)];
    assign b2 = mem[8'(addr[7:0] + 8'h02)];
    // Stores one byte.
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask
endmodule // cit_code_mem

// >>> tb/cit_timing_asserts.sv
// Port checker for the instruction timing decoder.
// Assumes clk is the only clock and srst a synchronous active-high reset.
`timescale 1ns/1ps
module cit_timing_asserts (
    input wire        clk,
    input wire        srst,
    input wire        issueValid,
    input wire [7:0]  opcode,
    input wire [7:0]  operandOne,
    input wire [15:0] nextPc,
    input wire        condTrue,
    input wire        sfrWrEn,
    input wire        sfrRdEn,
    input wire [7:0]  sfrAddr,
    input wire [7:0]  sfrWrData,
    input wire        sfrRdValid,
    input wire        busy,
    input wire        done,
    input wire [3:0]  cycleCount,
    input wire        branchTaken,
    input wire [15:0] targetAddr,
    input wire        directIsSfr,
    input wire [15:0] dataPointer,
    input wire [1:0]  bankSelect
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire         taken = issueValid && (!busy || done);
    logic [3:0]  age;
    logic [15:0] relTarget;
    logic [15:0] pageTarget;
    // Clocks since acceptance, and the targets expected for the issued bytes.
    always @(posedge clk) begin
        if (srst)
            age <= 4'h0;
        else if (taken)
            age <= 4'h1;
        else if (busy)
            age <= age + 4'h1;
        relTarget  <= nextPc + {{8{operandOne[7]}}, operandOne};
        pageTarget <= {nextPc[15:11], opcode[7:5], operandOne};
    end
    done_at_count_a: assert property (done |-> age == cycleCount)
        else $error("done not at its clock count");
    done_bounded_a: assert property (taken |-> ##[1:6] done)
        else $error("instruction did not finish");
    idle_one_clock_a: assert property (taken && (opcode == 8'h00 || opcode == 8'hA5) |=> done && cycleCount == 4'h1)
        else $error("idle opcode not one clock");
    carry_branch_a: assert property (taken && opcode == 8'h40 |=> cycleCount == ($past(condTrue) ? 4'h4 : 4'h2))
        else $error("carry branch count wrong");
    bit_branch_a: assert property (taken && opcode == 8'h20 |=> cycleCount == ($past(condTrue) ? 4'h5 : 4'h3))
        else $error("bit branch count wrong");
    short_jump_a: assert property (taken && opcode == 8'h80 |=> branchTaken && targetAddr == relTarget)
        else $error("short jump target wrong");
    page_jump_a: assert property (taken && opcode[4:0] == 5'h01 |=> targetAddr == pageTarget)
        else $error("page target wrong");
    sfr_space_a: assert property (taken |=> directIsSfr == ($past(operandOne) >= 8'h80))
        else $error("direct space select wrong");
    low_byte_wr_a: assert property (sfrWrEn && sfrAddr == 8'h82 && !taken |=> dataPointer[7:0] == $past(sfrWrData))
        else $error("low pointer byte not written");
    bank_wr_a: assert property (sfrWrEn && sfrAddr == 8'hD0 |=> {3'h0, bankSelect, 3'h0} == ($past(sfrWrData) & 8'h18))
        else $error("bank field not written");
    read_valid_a: assert property (sfrRdEn |=> sfrRdValid)
        else $error("read not answered");
    cover property (taken && opcode == 8'hB5 && condTrue);
    cover property (done && taken);
    cover property (sfrRdValid && sfrAddr == 8'hD0);
endmodule // cit_timing_asserts
bind cit_instruction_timing cit_timing_asserts chk_u (.*);

// >>> tb/cit_instruction_timing_tb_top.sv
// Self-checking bench for the instruction timing decoder, fed from a code memory.
// Assumes the decoder ports as declared and a 100 MHz clock.
`timescale 1ns/1ps
module cit_instruction_timing_tb_top;
    logic        clk, srst, issueValid, condTrue, sfrWrEn, sfrRdEn;
    logic [7:0]  accValue, sfrAddr, sfrWrData;
    logic [15:0] nextPc, fetchAddr, dp, pc;
    wire  [7:0]  opcode, operandOne, operandTwo, sfrRdData, regAddr, bitClearAddr;
    wire  [15:0] targetAddr, codeAddr, dataPointer;
    wire  [3:0]  cycleCount;
    wire  [1:0]  instrBytes, bankSelect;
    wire         sfrRdValid, busy, done, knownOp, branchTaken, targetValid, directIsSfr, bitClear;
    int          fails, checkCount, n;
    logic [31:0] rng;
    logic [1:0]  bank;
    // Opcode, then clocks when not taken and when taken.
    logic [15:0] ops [0:53] = '{
        16'h0011, 16'hA511, 16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hC411,
        16'hC311, 16'hD311, 16'hB311, 16'hC222, 16'hD222, 16'hB222, 16'h8222, 16'hB022, 16'hA022,
        16'h9222, 16'h7222, 16'hA222, 16'h8533, 16'h7533, 16'h9033, 16'h8333, 16'h9333,
        16'hE033, 16'hF033, 16'hE233, 16'hF333, 16'hC022, 16'hD022, 16'hD622, 16'hE722,
        16'h4024, 16'h5024, 16'h6024, 16'h7024, 16'hD824, 16'hDF24, 16'h2035, 16'h3035, 16'h1035,
        16'hB435, 16'hD535, 16'hB546, 16'hB646, 16'h8044, 16'h0144, 16'hE144, 16'h7344, 16'h0255,
        16'h1144, 16'h1255};

    cit_code_mem mem_u (.addr(fetchAddr), .b0(opcode), .b1(operandOne), .b2(operandTwo));
    cit_instruction_timing dut_u (.*);

    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Random source.
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Compares and counts.
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checkCount++;
        if (seen !== want) begin
            fails++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stopTest();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One register access; a read compares the answer one cycle later.
    task automatic sfrAccess(input logic wr, input logic [7:0] a, input logic [7:0] d);
        sfrWrEn <= wr;
        sfrRdEn <= !wr;
        sfrAddr <= a;
        sfrWrData <= d;
        @(posedge clk);
        sfrWrEn <= 1'b0;
        sfrRdEn <= 1'b0;
        @(negedge clk);
        if (!wr) begin
            chk(sfrRdValid, 16'h0001);
            chk(sfrRdData, d);
        end
        @(posedge clk);
    endtask

    // Issues one instruction; a held issue is taken again right at its done cycle.
    task automatic run(input logic [15:0] e, input logic hold);
        logic [7:0]  op, r1, r2, dsp, acc;
        logic [15:0] tgt, np;
        logic        br, cond;
        int          k;
        op = e[15:8];
        r1 = 8'(xs());
        r2 = 8'(xs());
        np = 16'(xs());
        cond = rng[20];
        acc = rng[31:24];
        pc = pc + 16'h0003;
        mem_u.put(pc[7:0], op);
        mem_u.put(pc[7:0] + 8'h01, r1);
        mem_u.put(pc[7:0] + 8'h02, r2);
        fetchAddr <= pc;
        nextPc <= np;
        condTrue <= cond;
        accValue <= acc;
        issueValid <= 1'b1;
        br = (e[7:4] != e[3:0]) ? cond : (e[7:4] >= 4'h4);
        dsp = (e[7:4] >= 4'h3 && e[7:4] != e[3:0]) ? r2 : r1;
        if (op == 8'h02 || op == 8'h12)
            tgt = {r1, r2};
        else if (op[3:0] == 4'h1)
            tgt = {np[15:11], op[7:5], r1};
        else if (op == 8'h73)
            tgt = dp + {8'h00, acc};
        else
            tgt = np + {{8{dsp[7]}}, dsp};
        @(posedge clk);
        for (k = 0; k <= hold; k++) begin
            if (k == hold)
                issueValid <= 1'b0;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (done !== 1'b1 && n < 12);
            if (done !== 1'b1) begin
                fails++;
                stopTest();
            end
            if (op == 8'h90)
                dp = {r1, r2};
            chk(16'(n), cond ? 16'(e[3:0]) : 16'(e[7:4]));
            chk(branchTaken, br);
            if (br)
                chk(targetAddr, tgt);
            chk(bitClear, op == 8'h10 && cond);
            chk(dataPointer, dp);
            chk(knownOp, 16'h0001);
            chk(targetValid, br);
            if (op == 8'h10)
                chk(bitClearAddr, r1);
            if (op == 8'h93)
                chk(codeAddr, dp + {8'h00, acc});
            else if (op == 8'h83)
                chk(codeAddr, np + {8'h00, acc});
            else if (op == 8'hE0 || op == 8'hF0)
                chk(codeAddr, dp);
            if (op inside {8'h85, 8'h75, 8'h90, 8'h02, 8'h12} || (e[7:4] >= 4'h3 && e[7:4] != e[3:0]))
                chk(instrBytes, 16'h0003);
            if (op[7:3] == 5'h1B)
                chk(regAddr, {3'h0, bank, op[2:0]});
            else if (op[3:1] == 3'h3)
                chk(regAddr, {3'h0, bank, 2'h0, op[0]});
        end
    endtask

    // Reset, register table, then every opcode of the ops table in every bank.
    initial begin
        rng = 32'd87916;
        {srst, issueValid, condTrue, sfrWrEn, sfrRdEn} = 5'h10;
        {accValue, sfrAddr, sfrWrData, nextPc, fetchAddr} = '0;
        {fails, checkCount, dp, pc, bank} = '0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        sfrAccess(1'b0, 8'h82, 8'h00);
        sfrAccess(1'b0, 8'h83, 8'h00);
        sfrAccess(1'b0, 8'hD0, 8'h00);
        $display("reset values done");
        for (int b = 0; b < 4; b++) begin
            bank = 2'(b);
            dp = 16'(xs());
            sfrAccess(1'b1, 8'h82, dp[7:0]);
            sfrAccess(1'b1, 8'h83, dp[15:8]);
            sfrAccess(1'b1, 8'hD0, {3'h0, bank, 3'h0});
            sfrAccess(1'b0, 8'h82, dp[7:0]);
            sfrAccess(1'b0, 8'h83, dp[15:8]);
            sfrAccess(1'b0, 8'hD0, {3'h0, bank, 3'h0});
            sfrAccess(1'b0, 8'h55, 8'h00);
            foreach (ops[i])
                run(ops[i], i % 5 == b);
            sfrAccess(1'b0, 8'h83, dp[15:8]);
            $display("bank %0d pass done", b);
        end
        stopTest();
    end
endmodule // cit_instruction_timing_tb_top
